/* File: rtl/ptcr_trace.sv */
/*
  Program trace control and readout: debug register decode, item formatter,
  an eight word item FIFO and the embedded trace buffer.
  Assumes the debug module and the pipeline both run on sys_clk, so their
  inputs are sampled directly; the buffer depth is a power of two.
*/
// Summary of operation
// - Setup and command registers are write-only; reads change nothing, return zero.
// - Each tracepoint bit turns a matching breakpoint hit into a trace start.
// - Level 00 complete, 01 flow, 10 event, 11 flow with cycles.
// - With full-halt set, request halt on buffer full or cycle overflow.
// - Save-counter stores new counter on taken branches, or calls at event level.
// - Save-load records load and stream get data values.
// - Save-return records the new counter of every return.
// - Clear command resets the status item count and overflow, and empties the trace buffer; the running flag is kept.
// - Start command begins tracing at once; stop command ends it at once.
// - Sample command captures the buffered item count into the status register.
// - Running flag is set on start and cleared on stop.
// - Overflow flag sets on cycle count overflow, stays until clear.
// - Status item count only changes on sample or clear, not with live fill.
// - Status and data registers are read-only; writes do nothing.
// - Data register shows the oldest item; each read advances the buffer.
// - Complete trace uses eight items; cycle count, status, destination fields.
// - Third complete item holds exception, load, store, byte enables, data.
// - Branch item: tag 00, count 1 to 12, taken bits from MSB.
// - Branch items are only emitted with a nonzero count; zero-count items never appear.
// - Counter value goes out as tag 01 items, upper half first.
// - Read data goes out as tag 10 items, upper half first.
// - Event items carry tag 11 and subtype 00 software, 10 cross-trigger.
// - Cycle counter covers 32768 complete, 8192 flow-cycle; beyond is overflow.
// - Buffer full stops tracing and clears the running flag.
`timescale 1ns/100ps
`default_nettype none

module ptcr_fifo #(
  parameter int W     = 18,
  parameter int DEPTH = 8
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic         clear,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] DEPTH_C = (PW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0]           wr;
    logic [PW-1:0]           rd;
    logic [PW:0]             cnt;
  } ptcr_fifo_state_type;

  ptcr_fifo_state_type q;
  ptcr_fifo_state_type d;

  function automatic logic [PW-1:0] wrap_inc(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction

  assign in_ready  = (q.cnt != DEPTH_C);
  assign out_valid = (q.cnt != '0);
  assign out_data  = q.mem[q.rd];

  always_comb begin
    logic push;
    logic pop;
    push = in_valid && in_ready;
    pop  = out_valid && out_ready;
    d = q;
    if (push) begin
      d.mem[q.wr] = in_data;
      d.wr        = wrap_inc(q.wr);
    end
    if (pop) begin
      d.rd = wrap_inc(q.rd);
    end
    d.cnt = q.cnt + (PW+1)'(push) - (PW+1)'(pop);
    if (clear) begin
      d.wr  = '0;
      d.rd  = '0;
      d.cnt = '0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule

module ptcr_trace #(
  parameter int       BUF_DEPTH  = 1024,
  parameter int       FIFO_DEPTH = 8,
  parameter bit       EXT_TRACE  = 1'b0
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  dbg_cmd,
  input  wire logic        dbg_wr_en,
  input  wire logic        dbg_rd_en,
  input  wire logic [31:0] dbg_wdata,
  output logic [17:0]      dbg_rdata,
  output logic             dbg_rvalid,
  input  wire logic        ins_valid,
  output logic             ins_ready,
  input  wire logic [31:0] ins_pc,
  input  wire logic [31:0] ins_new_pc,
  input  wire logic [31:0] ins_word,
  input  wire logic [31:0] ins_addr,
  input  wire logic [31:0] ins_data,
  input  wire logic [14:0] ins_msr,
  input  wire logic [4:0]  ins_dest_reg,
  input  wire logic        ins_dest_wr,
  input  wire logic        ins_is_load,
  input  wire logic        ins_is_store,
  input  wire logic        ins_is_get,
  input  wire logic [3:0]  ins_byte_en,
  input  wire logic        ins_exc_taken,
  input  wire logic [4:0]  ins_exc_kind,
  input  wire logic        ins_is_branch,
  input  wire logic        ins_taken,
  input  wire logic        ins_pc_indirect,
  input  wire logic        ins_is_call,
  input  wire logic        ins_is_return,
  input  wire logic        ins_sw_event,
  input  wire logic [13:0] ins_sw_value,
  input  wire logic [7:0]  ins_xtrig,
  input  wire logic [15:0] bp_hit,
  output logic             trace_running,
  output logic             dbg_halt_req
);
  localparam int IW = ptcr_pkg::ITEM_W;
  localparam int AW = $clog2(BUF_DEPTH);
  localparam logic [AW:0] BUF_DEPTH_C = (AW+1)'(BUF_DEPTH);

  typedef struct packed {
    logic [ptcr_pkg::SETUP_W-1:0]              setup;
    logic                                      running;
    logic                                      ovf;
    logic [ptcr_pkg::CNT_W-1:0]                item_cnt;
    logic [IW-1:0]                             rdata;
    logic                                      rvalid;
    logic                                      halt;
    logic [ptcr_pkg::SER_SLOTS-1:0][IW-1:0]    ser;
    logic [3:0]                                ser_cnt;
    logic [3:0]                                ser_idx;
    logic [3:0]                                br_cnt;
    logic [11:0]                               br_bits;
    logic [15:0]                               cyc;
    logic [AW-1:0]                             wr_ptr;
    logic [AW-1:0]                             rd_ptr;
    logic [AW:0]                               count;
  } ptcr_state_type;

  ptcr_state_type q;
  ptcr_state_type d;

  // Trace buffer storage; kept outside the state record so it maps to RAM.
  logic [IW-1:0] buf_mem [BUF_DEPTH];

  logic          fifo_in_valid;
  logic          fifo_in_ready;
  logic [IW-1:0] fifo_in_data;
  logic          fifo_out_valid;
  logic          fifo_out_ready;
  logic [IW-1:0] fifo_out_data;
  logic          cmd_wr;
  logic          cmd_clear;
  logic          buf_we;

  function automatic logic [AW-1:0] buf_inc(input logic [AW-1:0] p);
    return (p == AW'(BUF_DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  function automatic logic [1:0][IW-1:0] split_word(input logic [1:0] tag,
                                                    input logic [31:0] w);
    return {tag, w[31:16], tag, w[15:0]};
  endfunction

  ptcr_fifo #(
    .W     (IW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .clear     (cmd_clear),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // setup and command only take writes.
  assign cmd_wr    = dbg_wr_en && (dbg_cmd == ptcr_pkg::SEL_COMMAND);
  assign cmd_clear = cmd_wr && dbg_wdata[ptcr_pkg::CMD_CLEAR_BIT];

  assign fifo_in_valid  = (q.ser_idx != q.ser_cnt) && !cmd_clear;
  assign fifo_in_data   = q.ser[q.ser_idx[2:0]];
  assign fifo_out_ready = (q.count != BUF_DEPTH_C);
  assign buf_we         = fifo_out_valid && fifo_out_ready && !cmd_clear;

  // The pipeline only stalls while a record is still being itemised.
  assign ins_ready     = !q.running || (q.ser_idx == q.ser_cnt);
  assign trace_running = q.running;
  assign dbg_halt_req  = q.halt;
  assign dbg_rdata     = q.rdata;
  assign dbg_rvalid    = q.rvalid;

  always_comb begin
    logic [1:0]                           lvl;
    logic                                 accept;
    logic                                 flow;
    logic                                 need_new;
    logic                                 evt_any;
    logic                                 pop;
    logic                                 ovf_evt;
    logic [15:0]                          limit;
    logic [31:0]                          dval;
    logic [31:0]                          aval;
    logic [3:0]                           n;
    logic [ptcr_pkg::SER_SLOTS-1:0][IW-1:0] lst;
    logic [1:0][IW-1:0]                   pair;
    lvl      = q.setup[ptcr_pkg::LVL_LSB +: 2];
    accept   = ins_valid && ins_ready && q.running;
    flow     = 1'b0;
    need_new = 1'b0;
    evt_any  = 1'b0;
    pop      = 1'b0;
    ovf_evt  = 1'b0;
    limit    = 16'h0000;
    dval     = ins_data;
    aval     = (ins_is_load || ins_is_store) ? ins_addr : ins_word;
    n        = 4'h0;
    lst      = '0;
    pair     = '0;
    d        = q;
    d.rvalid = 1'b0;
    d.halt   = 1'b0;

    // complete trace is not offered with external trace.
    if (EXT_TRACE && lvl == ptcr_pkg::LVL_COMPLETE) begin
      lvl = ptcr_pkg::LVL_FLOW;
    end

    if (lvl == ptcr_pkg::LVL_COMPLETE) begin
      limit = ptcr_pkg::CYC_LIMIT_COMPLETE;
    end else if (lvl == ptcr_pkg::LVL_FLOW_CYC) begin
      limit = ptcr_pkg::CYC_LIMIT_FLOW;
    end

    if (fifo_in_valid && fifo_in_ready) begin
      d.ser_idx = q.ser_idx + 4'h1;
    end

    if (accept) begin
      d.cyc = 16'h0000;
      if (lvl == ptcr_pkg::LVL_COMPLETE) begin
        lst[0] = {q.cyc[14:0], ins_msr[14:12]};
        lst[1] = {ins_msr[11:0], ins_dest_reg, ins_dest_wr};
        // exception, access kind and data items.
        lst[2] = {ins_exc_kind, ins_exc_taken, ins_is_load, ins_is_store,
                  ins_byte_en, dval[31:26]};
        lst[3] = dval[25:8];
        lst[4] = {dval[7:0], aval[31:22]};
        lst[5] = aval[21:4];
        lst[6] = {aval[3:0], ins_pc[31:18]};
        lst[7] = ins_pc[17:0];
        n      = 4'h8;
      end else begin
        flow    = (lvl != ptcr_pkg::LVL_EVENT);
        evt_any = ins_sw_event || (ins_xtrig != 8'h00);
        // taken flags fill from the top bit down.
        if (flow && ins_is_branch) begin
          d.br_bits[4'hb - q.br_cnt] = ins_taken;
          d.br_cnt                   = q.br_cnt + 4'h1;
        end
        if (flow) begin
          // taken branches at the flow levels.
          need_new = ins_pc_indirect || ins_exc_taken
                  || (q.setup[ptcr_pkg::SAVE_CNT_BIT] && ins_is_branch && ins_taken)
                  || (q.setup[ptcr_pkg::SAVE_RET_BIT] && ins_is_return);
        end else begin
          // function calls at the event level.
          need_new = (q.setup[ptcr_pkg::SAVE_CNT_BIT] && ins_is_call)
                  || (q.setup[ptcr_pkg::SAVE_RET_BIT] && ins_is_return);
        end
        // flush the branch word when full or before a counter value.
        if (d.br_cnt == ptcr_pkg::MAX_BRANCHES
            || (d.br_cnt != 4'h0 && (need_new || evt_any))) begin
          lst[n[2:0]] = {ptcr_pkg::TAG_BRANCH, d.br_cnt, d.br_bits};
          n           = n + 4'h1;
          d.br_cnt    = 4'h0;
          d.br_bits   = 12'h000;
        end
        if (q.setup[ptcr_pkg::SAVE_LOAD_BIT] && (ins_is_load || ins_is_get)) begin
          pair          = split_word(ptcr_pkg::TAG_DATA, ins_data);
          lst[n[2:0]]   = pair[1];
          lst[3'(n + 4'h1)] = pair[0];
          n             = n + 4'h2;
        end
        // counter halves, upper first; events reuse it as their marker.
        if (need_new || evt_any) begin
          pair          = split_word(ptcr_pkg::TAG_PC, need_new ? ins_new_pc : ins_pc);
          lst[n[2:0]]   = pair[1];
          lst[3'(n + 4'h1)] = pair[0];
          n             = n + 4'h2;
        end
        if (ins_sw_event) begin
          lst[n[2:0]] = {ptcr_pkg::TAG_EVENT, ptcr_pkg::EVT_SW, ins_sw_value};
          n           = n + 4'h1;
        end
        if (ins_xtrig != 8'h00) begin
          lst[n[2:0]] = {ptcr_pkg::TAG_EVENT, ptcr_pkg::EVT_XTRIG, 6'h00, ins_xtrig};
          n           = n + 4'h1;
        end
      end
      d.ser     = lst;
      d.ser_cnt = n;
      d.ser_idx = 4'h0;
    end else if (q.running && limit != 16'h0000) begin
      // one cycle past the field's range counts as overflow.
      if (q.cyc == limit - 16'h0001) begin
        ovf_evt = 1'b1;
      end
      if (q.cyc != limit) begin
        d.cyc = q.cyc + 16'h0001;
      end
    end else if (!q.running) begin
      d.cyc = 16'h0000;
    end

    // Buffer fill and drain.
    if (buf_we) begin
      d.wr_ptr = buf_inc(q.wr_ptr);
    end
    // pop the oldest item on each read.
    if (dbg_rd_en && dbg_cmd == ptcr_pkg::SEL_POP) begin
      d.rvalid = 1'b1;
      d.rdata  = (q.count != '0) ? buf_mem[q.rd_ptr] : '0;
      pop      = (q.count != '0);
      if (pop) begin
        d.rd_ptr = buf_inc(q.rd_ptr);
      end
    end else if (dbg_rd_en) begin
      d.rvalid = 1'b1;
      // write-only registers read as zero, no side effect.
      d.rdata  = '0;
      if (dbg_cmd == ptcr_pkg::SEL_STATE) begin
        d.rdata = {q.running, q.ovf, q.item_cnt};
      end
    end
    d.count = q.count + (AW+1)'(buf_we) - (AW+1)'(pop);

    // only setup and command selectors accept writes.
    if (dbg_wr_en && dbg_cmd == ptcr_pkg::SEL_SETUP) begin
      d.setup = dbg_wdata[ptcr_pkg::SETUP_W-1:0];
    end

    if (cmd_wr) begin
      if (dbg_wdata[ptcr_pkg::CMD_CLEAR_BIT]) begin
        // read position returns to the start too.
        d.ovf      = 1'b0;
        d.item_cnt = '0;
        d.wr_ptr   = '0;
        d.rd_ptr   = '0;
        d.count    = '0;
        d.ser_cnt  = 4'h0;
        d.ser_idx  = 4'h0;
        d.br_cnt   = 4'h0;
        d.br_bits  = 12'h000;
      end
      if (dbg_wdata[ptcr_pkg::CMD_START_BIT]) begin
        d.running = 1'b1;
      end
      // stop at once; stop wins over a start in the same write.
      if (dbg_wdata[ptcr_pkg::CMD_STOP_BIT]) begin
        d.running = 1'b0;
      end
      if (dbg_wdata[ptcr_pkg::CMD_SAMPLE_BIT]) begin
        d.item_cnt = ptcr_pkg::CNT_W'(d.count);
      end
    end

    if ((bp_hit & q.setup[ptcr_pkg::TP_LSB +: ptcr_pkg::TP_W]) != 16'h0000) begin
      d.running = 1'b1;
    end

    // a full buffer stops tracing, overriding any start.
    if (d.count == BUF_DEPTH_C) begin
      d.running = 1'b0;
    end

    // overflow is sticky; an overflow beats a clear in the same cycle.
    if (ovf_evt) begin
      d.ovf = 1'b1;
    end

    // halt request on buffer becoming full or overflow.
    if (q.setup[ptcr_pkg::FULL_HALT_BIT]
        && (ovf_evt || (d.count == BUF_DEPTH_C && q.count != BUF_DEPTH_C))) begin
      d.halt = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (buf_we) begin
      buf_mem[q.wr_ptr] <= fifo_out_data;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q       <= '0;
      q.setup <= ptcr_pkg::SETUP_RST;
    end else begin
      q <= d;
    end
  end
endmodule

`default_nettype wire

/* File: rtl/ptcr_pkg.sv */
/*
  Constants for the program trace control and readout block: debug register
  selector codes, field positions, item tags and cycle limits.
  Assumes nothing of its surroundings; every design file refers to it by scope.
*/
package ptcr_pkg;

  // Debug register selector codes carried on dbg_cmd.
  localparam logic [7:0] SEL_SETUP   = 8'h61;
  localparam logic [7:0] SEL_COMMAND = 8'h62;
  localparam logic [7:0] SEL_STATE   = 8'h63;
  localparam logic [7:0] SEL_POP     = 8'h66;

  // Trace setup register layout.
  localparam int SETUP_W       = 22;
  localparam int TP_LSB        = 6;
  localparam int TP_W          = 16;
  localparam int LVL_LSB       = 4;
  localparam int FULL_HALT_BIT = 3;
  localparam int SAVE_CNT_BIT  = 2;
  localparam int SAVE_LOAD_BIT = 1;
  localparam int SAVE_RET_BIT  = 0;
  localparam logic [SETUP_W-1:0] SETUP_RST = 22'h00_0000;

  // Trace command register bits.
  localparam int CMD_W         = 4;
  localparam int CMD_CLEAR_BIT = 3;
  localparam int CMD_START_BIT = 2;
  localparam int CMD_STOP_BIT  = 1;
  localparam int CMD_SAMPLE_BIT = 0;

  // Trace state register layout.
  localparam int RUN_BIT = 17;
  localparam int OVF_BIT = 16;
  localparam int CNT_W   = 16;

  // Trace items.
  localparam int ITEM_W    = 18;
  localparam int SER_SLOTS = 8;
  localparam logic [1:0] TAG_BRANCH = 2'h0;
  localparam logic [1:0] TAG_PC     = 2'h1;
  localparam logic [1:0] TAG_DATA   = 2'h2;
  localparam logic [1:0] TAG_EVENT  = 2'h3;
  localparam logic [1:0] EVT_SW     = 2'h0;
  localparam logic [1:0] EVT_XTRIG  = 2'h2;
  localparam logic [3:0] MAX_BRANCHES = 4'hc;

  // Cycle counter limits.
  localparam logic [15:0] CYC_LIMIT_COMPLETE = 16'h8000;
  localparam logic [15:0] CYC_LIMIT_FLOW     = 16'h2000;

  typedef enum logic [1:0] {
    LVL_COMPLETE = 2'h0,
    LVL_FLOW     = 2'h1,
    LVL_EVENT    = 2'h2,
    LVL_FLOW_CYC = 2'h3
  } ptcr_level_type;

endpackage

/* File: tb/ptcr_trace_sva.sv */
/*
  Port checker for ptcr_trace: register answers, run flag causes, halt pulse.
  Assumes it is bound to ptcr_trace and that all ports share sys_clk.
*/
`timescale 1ns/100ps
`default_nettype none
module ptcr_trace_sva (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic [7:0]  dbg_cmd,
  input wire logic        dbg_wr_en,
  input wire logic        dbg_rd_en,
  input wire logic [31:0] dbg_wdata,
  input wire logic [17:0] dbg_rdata,
  input wire logic        dbg_rvalid,
  input wire logic        ins_ready,
  input wire logic [15:0] bp_hit,
  input wire logic        trace_running,
  input wire logic        dbg_halt_req
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic cmd_wr;
  logic start_cause;
  assign cmd_wr = dbg_wr_en && dbg_cmd == ptcr_pkg::SEL_COMMAND;
  assign start_cause = (cmd_wr && dbg_wdata[2]) || (|bp_hit);
  rd_answer_a: assert property (dbg_rd_en |=> dbg_rvalid)
    else $error("read not answered");
  rvalid_cause_a: assert property (!dbg_rd_en |=> !dbg_rvalid)
    else $error("read answer without request");
  rdata_hold_a: assert property (!dbg_rd_en |=> $stable(dbg_rdata))
    else $error("read data moved without read");
  wo_read_zero_a: assert property (dbg_rd_en && (dbg_cmd == ptcr_pkg::SEL_SETUP
    || dbg_cmd == ptcr_pkg::SEL_COMMAND) |=> dbg_rvalid && dbg_rdata == 18'h0_0000)
    else $error("write-only register read not zero");
  start_runs_a: assert property (cmd_wr && dbg_wdata[2] && !dbg_wdata[1] |=> trace_running)
    else $error("start did not run");
  stop_halts_a: assert property (cmd_wr && dbg_wdata[1] |=> !trace_running)
    else $error("stop did not end run");
  ro_write_a: assert property (dbg_wr_en && (dbg_cmd == ptcr_pkg::SEL_STATE
    || dbg_cmd == ptcr_pkg::SEL_POP) |=> $stable(trace_running))
    else $error("read-only write changed state");
  run_cause_a: assert property ($rose(trace_running) |-> $past(start_cause))
    else $error("run began without cause");
  halt_pulse_a: assert property (dbg_halt_req |=> !dbg_halt_req)
    else $error("halt request longer than one cycle");
  idle_ready_a: assert property (!trace_running |-> ins_ready)
    else $error("records refused while stopped");
  cover property ($rose(trace_running));
  cover property (dbg_halt_req);
  cover property ($fell(trace_running) && !cmd_wr);
endmodule
`default_nettype wire

/* File: tb/ptcr_dbg_host.sv */
/*
  Debug module model: writes and reads the trace debug registers.
  Assumes one-cycle strobes driven at the falling edge of sys_clk.
*/
`timescale 1ns/100ps
`default_nettype none
module ptcr_dbg_host (
  input  wire logic        sys_clk,
  output logic [7:0]       dbg_cmd,
  output logic             dbg_wr_en,
  output logic             dbg_rd_en,
  output logic [31:0]      dbg_wdata,
  input  wire logic [17:0] dbg_rdata,
  input  wire logic        dbg_rvalid
);
  initial begin
    dbg_cmd = 8'h00;
    dbg_wr_en = 1'b0;
    dbg_rd_en = 1'b0;
    dbg_wdata = 32'h0000_0000;
  end
  // Idle lines show the inverse of the last value so stale data never matches.
  task automatic wr(input logic [7:0] sel, input logic [31:0] d);
    @(negedge sys_clk);
    dbg_cmd = sel;
    dbg_wdata = d;
    dbg_wr_en = 1'b1;
    @(negedge sys_clk);
    dbg_wr_en = 1'b0;
    dbg_cmd = ~sel;
    dbg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] sel, output logic [17:0] d);
    @(negedge sys_clk);
    dbg_cmd = sel;
    dbg_rd_en = 1'b1;
    @(negedge sys_clk);
    // The answer stands for one cycle only, so it is taken before the strobe drops.
    d = (dbg_rvalid === 1'b1) ? dbg_rdata : 18'hx;
    dbg_rd_en = 1'b0;
    dbg_cmd = ~sel;
  endtask
endmodule
`default_nettype wire

/* File: tb/tb.sv */
/*
  Self-checking bench for ptcr_trace with a queue model of trace items.
  Assumes ptcr_pkg, ptcr_trace, the checker and the host model compile first.
*/
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam int BUF_D = 16;
  logic        sys_clk, rst_n, dbg_wr_en, dbg_rd_en, dbg_rvalid, ok;
  logic        ins_valid, ins_ready, trace_running, dbg_halt_req, ins_dest_wr;
  logic        ins_is_load, ins_is_store, ins_is_get, ins_exc_taken, ins_is_branch;
  logic        ins_taken, ins_pc_indirect, ins_is_call, ins_is_return, ins_sw_event;
  logic [7:0]  dbg_cmd, ins_xtrig;
  logic [31:0] dbg_wdata, ins_pc, ins_new_pc, ins_word, ins_addr, ins_data, r;
  logic [17:0] dbg_rdata, got;
  logic [14:0] ins_msr;
  logic [4:0]  ins_dest_reg, ins_exc_kind;
  logic [3:0]  ins_byte_en;
  logic [13:0] ins_sw_value;
  logic [15:0] bp_hit;
  logic [11:0] bb;
  logic [17:0] q[$];
  int          err_total, n_checks, cyc, i, n, n_halts, nb;

  ptcr_dbg_host host (.sys_clk, .dbg_cmd, .dbg_wr_en, .dbg_rd_en, .dbg_wdata,
    .dbg_rdata, .dbg_rvalid);
  ptcr_trace #(.BUF_DEPTH(BUF_D)) DUT (.sys_clk, .rst_n, .dbg_cmd, .dbg_wr_en,
    .dbg_rd_en, .dbg_wdata, .dbg_rdata, .dbg_rvalid, .ins_valid, .ins_ready, .ins_pc,
    .ins_new_pc, .ins_word, .ins_addr, .ins_data, .ins_msr, .ins_dest_reg, .ins_dest_wr,
    .ins_is_load, .ins_is_store, .ins_is_get, .ins_byte_en, .ins_exc_taken,
    .ins_exc_kind, .ins_is_branch, .ins_taken, .ins_pc_indirect, .ins_is_call,
    .ins_is_return, .ins_sw_event, .ins_sw_value, .ins_xtrig, .bp_hit,
    .trace_running, .dbg_halt_req);

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk_item(input logic [17:0] g, input logic [17:0] e);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("Error %0t item got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_flag(input logic g, input logic e);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("Error %0t flag got %b expected %b", $time, g, e);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Flow level record: loaded data, or a software event preceded by its counter.
  task automatic rec(input logic ld, output logic acc);
    int k;
    acc = 1'b0;
    r = lfsr(r);
    ins_pc = r;
    ins_data = ~r;
    ins_word = r ^ 32'h5a5a_5a5a;
    ins_addr = {r[15:0], r[31:16]};
    ins_new_pc = r + 32'h0000_0100;
    {ins_msr, ins_dest_reg, ins_byte_en, ins_exc_kind} = r[28:0];
    {ins_is_store, ins_dest_wr, ins_is_call, ins_is_return} = r[13:10];
    ins_is_load = ld & ~r[14];
    ins_is_get = ld & r[14];
    ins_sw_event = ~ld;
    ins_sw_value = r[13:0];
    ins_is_branch = ld & r[15];
    ins_taken = r[16];
    ins_xtrig = ld ? 8'h00 : r[23:16];
    for (k = 0; k < 12 && !acc; k++) begin
      @(negedge sys_clk);
      ins_valid = 1'b1;
      #1;
      acc = ((ins_ready && trace_running) === 1'b1);
      @(posedge sys_clk);
    end
    @(negedge sys_clk);
    ins_valid = 1'b0;
    // flags pack from the top and flush at twelve or before an event.
    if (acc && ins_is_branch) begin
      bb[11 - nb] = ins_taken;
      nb++;
    end
    if (acc && nb > 0 && (nb == 12 || !ld)) begin
      q.push_back({ptcr_pkg::TAG_BRANCH, 4'(nb), bb});
      nb = 0;
      bb = 12'h000;
    end
    if (acc && ld) begin
      q.push_back({ptcr_pkg::TAG_DATA, ins_data[31:16]});
      q.push_back({ptcr_pkg::TAG_DATA, ins_data[15:0]});
    end
    if (acc && !ld) begin
      q.push_back({ptcr_pkg::TAG_PC, ins_pc[31:16]});
      q.push_back({ptcr_pkg::TAG_PC, ins_pc[15:0]});
      q.push_back({ptcr_pkg::TAG_EVENT, ptcr_pkg::EVT_SW, ins_sw_value});
      if (ins_xtrig != 8'h00) begin
        q.push_back({ptcr_pkg::TAG_EVENT, ptcr_pkg::EVT_XTRIG, 6'h00, ins_xtrig});
      end
    end
    repeat (4) @(negedge sys_clk);
  endtask

  task automatic pop_n(input int cnt);
    int k;
    for (k = 0; k < cnt; k++) begin
      host.rd(ptcr_pkg::SEL_POP, got);
      chk_item(got, q.pop_front());
    end
  endtask

  task automatic state_is(input logic [17:0] e);
    host.rd(ptcr_pkg::SEL_STATE, got);
    chk_item(got, e);
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (dbg_halt_req === 1'b1) n_halts <= n_halts + 1;
    if (cyc == 20000) begin
      err_total++;
      $display("Error %0t run did not finish", $time);
      tally_and_finish;
    end
  end

  initial begin
    rst_n = 1'b0;
    bb = 12'h000;
    r = 32'h0001_7299;
    {ins_valid, ins_pc, ins_new_pc, ins_word, ins_addr, ins_data, ins_msr} = '0;
    {ins_dest_reg, ins_dest_wr, ins_is_load, ins_is_store, ins_is_get, ins_byte_en} = '0;
    {ins_exc_taken, ins_exc_kind, ins_is_branch, ins_taken, ins_pc_indirect} = '0;
    {ins_is_call, ins_is_return, ins_sw_event, ins_sw_value, ins_xtrig, bp_hit} = '0;
    repeat (10) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_n = 1'b1;
    state_is(18'h0_0000);
    host.rd(ptcr_pkg::SEL_POP, got);
    chk_item(got, 18'h0_0000);
    host.wr(ptcr_pkg::SEL_SETUP, 32'h0000_0012);
    host.rd(ptcr_pkg::SEL_SETUP, got);
    chk_item(got, 18'h0_0000);
    host.wr(ptcr_pkg::SEL_COMMAND, 32'h0000_0004);
    chk_flag(trace_running, 1'b1);
    rec(1'b1, ok);
    rec(1'b0, ok);
    host.wr(ptcr_pkg::SEL_COMMAND, 32'h0000_0002);
    chk_flag(trace_running, 1'b0);
    host.wr(ptcr_pkg::SEL_COMMAND, 32'h0000_0001);
    host.wr(ptcr_pkg::SEL_STATE, 32'h0003_ffff);
    host.wr(ptcr_pkg::SEL_POP, 32'h0003_ffff);
    n = q.size();
    state_is({2'b00, 16'(n)});
    pop_n(n);
    state_is({2'b00, 16'(n)});
    host.wr(ptcr_pkg::SEL_COMMAND, 32'h0000_0009);
    state_is(18'h0_0000);
    host.wr(ptcr_pkg::SEL_SETUP, 32'h0000_0210);
    @(negedge sys_clk);
    bp_hit = 16'h0004;
    @(negedge sys_clk);
    bp_hit = 16'h0000;
    @(negedge sys_clk);
    chk_flag(trace_running, 1'b0);
    bp_hit = 16'h0008;
    @(negedge sys_clk);
    bp_hit = 16'h0000;
    @(negedge sys_clk);
    chk_flag(trace_running, 1'b1);
    host.wr(ptcr_pkg::SEL_COMMAND, 32'h0000_0002);
    host.wr(ptcr_pkg::SEL_SETUP, 32'h0000_0018);
    host.wr(ptcr_pkg::SEL_COMMAND, 32'h0000_000c);
    n = n_halts;
    for (i = 0; i < 10 && trace_running === 1'b1; i++) rec(1'b0, ok);
    chk_flag(trace_running, 1'b0);
    chk_flag(n_halts > n, 1'b1);
    host.wr(ptcr_pkg::SEL_COMMAND, 32'h0000_0001);
    state_is(18'(BUF_D));
    pop_n(BUF_D);
    repeat (8) @(negedge sys_clk);
    host.wr(ptcr_pkg::SEL_COMMAND, 32'h0000_0001);
    n = q.size();
    state_is({2'b00, 16'(n)});
    pop_n(n);
    // Flow with cycle count, no records: overflow comes 8192 cycles after start.
    host.wr(ptcr_pkg::SEL_SETUP, 32'h0000_0038);
    host.wr(ptcr_pkg::SEL_COMMAND, 32'h0000_000d);
    n = n_halts;
    repeat (8150) @(negedge sys_clk);
    state_is(18'h2_0000);
    repeat (100) @(negedge sys_clk);
    state_is(18'h3_0000);
    chk_flag(n_halts > n, 1'b1);
    host.wr(ptcr_pkg::SEL_COMMAND, 32'h0000_0002);
    state_is(18'h1_0000);
    tally_and_finish;
  end
endmodule

bind ptcr_trace ptcr_trace_sva sva (.sys_clk, .rst_n, .dbg_cmd, .dbg_wr_en, .dbg_rd_en,
  .dbg_wdata, .dbg_rdata, .dbg_rvalid, .ins_ready, .bp_hit, .trace_running, .dbg_halt_req);
`default_nettype wire
